//--- logic/ccp_pkg.sv
// Constants, register map and types for the I2C configuration port
package ccp_pkg;
  localparam int unsigned NREG = 6;
  localparam logic [7:0] REG_GEN_CTRL   = 8'h00;
  localparam logic [7:0] REG_VARIANT_ID = 8'h01;
  localparam logic [7:0] REG_XTAL_TRIM  = 8'h02;
  localparam logic [7:0] REG_PLLC_REF   = 8'h03;
  localparam logic [7:0] REG_PLLC_FB_LO = 8'h04;
  localparam logic [7:0] REG_PLLC_FB_HI = 8'h05;
  // Reset values
  localparam logic [7:0] RST_GEN_CTRL   = 8'h00;
  localparam logic [7:0] RST_VARIANT_ID = 8'h00;
  localparam logic [7:0] RST_XTAL_TRIM  = 8'h11;
  localparam logic [7:0] RST_PLLC_REF   = 8'h19;
  localparam logic [7:0] RST_PLLC_FB_LO = 8'hE0;
  localparam logic [7:0] RST_PLLC_FB_HI = 8'h11;
  // Field positions of the general control register
  localparam int unsigned B_NVM_PROG  = 7;
  localparam int unsigned B_ADDR_HI   = 6;
  localparam int unsigned B_ADDR_LO   = 5;
  localparam int unsigned B_SPREAD    = 4;
  localparam int unsigned B_OD1_SRC   = 3;
  localparam int unsigned B_PLLC_REF  = 2;
  localparam int unsigned B_NVM_LOCK  = 0;
  localparam logic [7:0]  GEN_WMASK   = 8'hFD;
  // Register 03h fields and the divider width of register 05h
  localparam int unsigned B_BYP_ONE   = 7;
  localparam int unsigned B_BYP_TWO   = 6;
  localparam int unsigned MDIV_W      = 6;
  localparam int unsigned FBHI_W      = 3;
  // Bus address base (7-bit form of D0)
  localparam logic [6:0]  ADDR_BASE   = 7'h68;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R
  } ccp_state_t;
  typedef struct packed {
    ccp_state_t             st;
    logic [2:0]             bitn;
    logic [7:0]             shf;
    logic                   rw;
    logic                   have_ptr;
    logic [7:0]             ptr;
    logic [NREG-1:0][7:0]   regs;
    logic [NREG-1:0][7:0]   stage;
    logic [NREG-1:0]        dirty;
    logic [2:0]             s_scl;
    logic [2:0]             s_sda;
    logic                   sda_oe_n;
  } ccp_st_t;
endpackage

//--- logic/ccp_port.sv
// I2C target port with staged register bank
`timescale 1ns/100ps
module ccp_port
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // I2C pins (open drain, oe low means pulling low)
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // Control outputs
  output logic            nvm_programmed_o,
  output logic [1:0]      addr_select_o,
  output logic            pll_a_spread_enable_o,
  output logic            outdiv_one_source_select_o,
  output logic            pll_c_reference_select_o,
  output logic            nvm_write_lock_o,
  output logic [7:0]      variant_identifier_o,
  output logic [7:0]      crystal_load_trim_o,
  output logic            pll_c_ref_bypass_one_o,
  output logic            pll_c_ref_bypass_two_o,
  output logic [5:0]      pll_c_ref_div_o,
  output logic [10:0]     pll_c_fb_div_o
);
  ccp_st_t r_reg, r_next;

  // Pointer in range
  function automatic logic valid(input logic [7:0] a);
    return a < 8'(NREG);
  endfunction

  // Byte shown for a read; past the bank the port answers zero, so a
  // long block read never picks up a stale shifter value
  function automatic logic [7:0] rd_byte(input logic [NREG-1:0][7:0] bank,
                                         input logic [7:0]            a);
    return valid(a) ? bank[a[2:0]] : 8'h00;
  endfunction

  logic scl_rise, scl_fall, start_c, stop_c, scl_s, sda_s;
  logic [6:0] my_addr;
  // Synchronised levels come from the second stage onward only
  assign scl_s    = r_reg.s_scl[1];
  assign sda_s    = r_reg.s_sda[1];
  assign scl_rise = r_reg.s_scl[1] & ~r_reg.s_scl[2];
  assign scl_fall = ~r_reg.s_scl[1] & r_reg.s_scl[2];
  assign start_c  = scl_s & r_reg.s_scl[2] & ~sda_s & r_reg.s_sda[2];
  assign stop_c   = scl_s & r_reg.s_scl[2] & sda_s & ~r_reg.s_sda[2];
  // Address picked by control bits 6:5
  assign my_addr  = ADDR_BASE + 7'(
                    r_reg.regs[REG_GEN_CTRL][B_ADDR_HI:B_ADDR_LO]);

  // Protocol and register state update
  always_comb begin
    r_next = r_reg;
    r_next.s_scl = {r_reg.s_scl[1:0], scl_i};
    r_next.s_sda = {r_reg.s_sda[1:0], sda_i};
    if (stop_c) begin
      // Commit all staged bytes at once
      for (int i = 0; i < NREG; i++) begin
        if (r_reg.dirty[i]) begin
          r_next.regs[i] = r_reg.stage[i];
        end
      end
      r_next.regs[REG_GEN_CTRL] =
        r_next.regs[REG_GEN_CTRL] & GEN_WMASK;
      r_next.regs[REG_PLLC_FB_HI][7:FBHI_W] =
        r_reg.regs[REG_PLLC_FB_HI][7:FBHI_W];
      r_next.dirty    = '0;
      r_next.st       = ST_IDLE;
      r_next.sda_oe_n = 1'b1;
    end else if (start_c) begin
      // Clear the shifter: a leftover byte would pass for an address
      r_next.st       = ST_ADDR;
      r_next.shf      = '0;
      r_next.bitn     = '0;
      r_next.sda_oe_n = 1'b1;
    end else begin
      case (r_reg.st)
        ST_IDLE: begin
          r_next.sda_oe_n = 1'b1;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            r_next.shf  = {r_reg.shf[6:0], sda_s};
            r_next.bitn = r_reg.bitn + 3'h1;
          end
          // The SCL fall just after a start finds an empty shifter and
          // is skipped; only the fall after eight bits takes the address
          if (scl_fall && r_reg.bitn == '0 && r_reg.shf != '0
              && r_reg.st == ST_ADDR) begin
            if (r_reg.shf[7:1] == my_addr) begin
              r_next.rw       = r_reg.shf[0];
              r_next.have_ptr = 1'b0;
              r_next.sda_oe_n = 1'b0;
              r_next.st       = ST_ACK_ADDR;
            end else begin
              r_next.st = ST_IDLE;
            end
          end else if (scl_fall && r_reg.bitn == '0
                       && r_reg.st == ST_WDATA) begin
            r_next.sda_oe_n = 1'b0;
            r_next.st       = ST_ACK_W;
            if (!r_reg.have_ptr) begin
              r_next.ptr      = r_reg.shf;
              r_next.have_ptr = 1'b1;
            end else begin
              if (valid(r_reg.ptr)) begin
                r_next.stage[r_reg.ptr[2:0]] = r_reg.shf;
                r_next.dirty[r_reg.ptr[2:0]] = 1'b1;
              end
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_W: begin
          if (scl_fall) begin
            if (r_reg.st == ST_ACK_ADDR && r_reg.rw) begin
              r_next.shf      = rd_byte(r_reg.regs, r_reg.ptr);
              r_next.sda_oe_n = r_next.shf[7];
              r_next.bitn     = '0;
              r_next.st       = ST_RDATA;
            end else begin
              r_next.sda_oe_n = 1'b1;
              r_next.bitn     = '0;
              r_next.shf      = '0;
              r_next.st       = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (r_reg.bitn == BIT_LAST) begin
              r_next.sda_oe_n = 1'b1;
              r_next.ptr      = r_reg.ptr + 8'h01;
              r_next.st       = ST_ACK_R;
            end else begin
              r_next.shf      = {r_reg.shf[6:0], 1'b0};
              r_next.sda_oe_n = r_reg.shf[6];
              r_next.bitn     = r_reg.bitn + 3'h1;
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            r_next.rw = ~sda_s; // Nack ends the block
          end
          if (scl_fall) begin
            if (r_reg.rw) begin
              r_next.shf      = rd_byte(r_reg.regs, r_reg.ptr);
              r_next.sda_oe_n = r_next.shf[7];
              r_next.bitn     = '0;
              r_next.st       = ST_RDATA;
            end else begin
              r_next.st = ST_IDLE;
            end
          end
        end
        default: r_next.st = ST_IDLE;
      endcase
    end
  end

  // State register with defaults loaded on reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Only the divider bits of the feedback high default are kept
      r_reg <= '{st: ST_IDLE, bitn: '0, shf: '0, rw: 1'b0, have_ptr: 1'b0,
                 ptr: '0,
                 regs: {8'(RST_PLLC_FB_HI[FBHI_W-1:0]), RST_PLLC_FB_LO,
                        RST_PLLC_REF, RST_XTAL_TRIM, RST_VARIANT_ID,
                        RST_GEN_CTRL},
                 stage: '0, dirty: '0, s_scl: 3'h7, s_sda: 3'h7,
                 sda_oe_n: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  // Pin outputs: SDA is open drain, so its data side is tied low and only
  // the registered enable moves, which keeps glitches off the bus
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = r_reg.sda_oe_n;

  // General control fields, straight from the committed byte
  assign nvm_programmed_o           =
    r_reg.regs[REG_GEN_CTRL][B_NVM_PROG];
  assign addr_select_o              =
    r_reg.regs[REG_GEN_CTRL][B_ADDR_HI:B_ADDR_LO];
  assign pll_a_spread_enable_o      =
    r_reg.regs[REG_GEN_CTRL][B_SPREAD];
  assign outdiv_one_source_select_o =
    r_reg.regs[REG_GEN_CTRL][B_OD1_SRC];
  assign pll_c_reference_select_o   =
    r_reg.regs[REG_GEN_CTRL][B_PLLC_REF];
  assign nvm_write_lock_o           =
    r_reg.regs[REG_GEN_CTRL][B_NVM_LOCK];

  // Identifier and crystal trim are plain bytes
  assign variant_identifier_o       = r_reg.regs[REG_VARIANT_ID];
  assign crystal_load_trim_o        = r_reg.regs[REG_XTAL_TRIM];

  // Third PLL dividers; the feedback value spans two bytes, which only
  // move together at a stop, so the divider never sees a half update
  assign pll_c_ref_bypass_one_o     =
    r_reg.regs[REG_PLLC_REF][B_BYP_ONE];
  assign pll_c_ref_bypass_two_o     =
    r_reg.regs[REG_PLLC_REF][B_BYP_TWO];
  assign pll_c_ref_div_o            =
    r_reg.regs[REG_PLLC_REF][MDIV_W-1:0];
  assign pll_c_fb_div_o             =
    {r_reg.regs[REG_PLLC_FB_HI][FBHI_W-1:0],
     r_reg.regs[REG_PLLC_FB_LO]};

  // Committed bytes move only at a stop
  chk_commit_on_stop: assert property (@(posedge clk_i)
    disable iff (srst_i) !stop_c |=> $stable(r_reg.regs))
    else $error("registers changed without a stop");

  // A stop empties the stage and frees the bus
  chk_commit_clear: assert property (@(posedge clk_i)
    disable iff (srst_i) stop_c |=> (r_reg.dirty == '0
      && r_reg.st == ST_IDLE && r_reg.sda_oe_n))
    else $error("stop left the port busy");

  // A start clears the shifter, so no stale byte is taken as an address
  chk_start_clear: assert property (@(posedge clk_i)
    disable iff (srst_i) start_c |=> (r_reg.st == ST_ADDR
      && r_reg.shf == '0 && r_reg.bitn == '0))
    else $error("start did not reset the shifter");

  // Address ack follows a matching address
  chk_addr_ack: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_ACK_ADDR) |-> !r_reg.sda_oe_n)
    else $error("address ack not driven");

  // A foreign address is left alone until the next start
  chk_addr_foreign: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_ADDR && scl_fall
      && r_reg.bitn == '0 && r_reg.shf != '0 && !start_c && !stop_c
      && r_reg.shf[7:1] != my_addr) |=> (r_reg.st == ST_IDLE
      && sda_oe_n_o))
    else $error("foreign address not ignored");

  // Write ack drives low
  chk_data_ack: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_ACK_W) |-> !sda_oe_n_o)
    else $error("write ack missing");

  // The master owns SDA while a write byte comes in
  chk_wdata_release: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_WDATA) |-> sda_oe_n_o)
    else $error("driving during a write byte");

  // First byte after a write address loads the pointer
  chk_ptr_load: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_WDATA && r_next.st == ST_ACK_W
      && !r_reg.have_ptr) |=> (r_reg.have_ptr
      && r_reg.ptr == $past(r_reg.shf)))
    else $error("pointer not loaded");

  // Each data byte moves the pointer on by one
  chk_ptr_write_adv: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_WDATA && r_next.st == ST_ACK_W
      && r_reg.have_ptr) |=> r_reg.ptr == $past(r_reg.ptr) + 8'h01)
    else $error("no advance after a write byte");

  // Reserved control bit stays zero
  chk_reserved_zero: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.regs[REG_GEN_CTRL] & ~GEN_WMASK) == '0)
    else $error("reserved bit set");

  // Pointer advances after a read byte
  chk_read_adv: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_RDATA && r_next.st == ST_ACK_R
      && !start_c && !stop_c) |=> r_reg.ptr == $past(r_reg.ptr) + 8'h01)
    else $error("no advance after a read byte");

  // Read bits leave MSB first from the top of the shifter
  chk_read_msb: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_RDATA)
      |-> (sda_oe_n_o == r_reg.shf[7]))
    else $error("read bit out of order");

  // The master owns SDA in the ack slot after a read byte
  chk_ack_r_release: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_ACK_R) |-> sda_oe_n_o)
    else $error("driving in the read ack slot");

  // Release bus in idle
  chk_idle_release: assert property (@(posedge clk_i)
    disable iff (srst_i) (r_reg.st == ST_IDLE) |-> sda_oe_n_o)
    else $error("driving in idle");

  // Top address code maps onto the top bus address
  chk_addr_map: assert property (@(posedge clk_i)
    disable iff (srst_i) addr_select_o == 2'b11 |-> my_addr == 7'h6B)
    else $error("address map wrong");

  // Upper bits of the feedback high byte never take write data
  chk_fb_hi: assert property (@(posedge clk_i)
    disable iff (srst_i) stop_c |=> r_reg.regs[REG_PLLC_FB_HI][7:FBHI_W]
      == $past(r_reg.regs[REG_PLLC_FB_HI][7:FBHI_W]))
    else $error("feedback high byte upper bits moved");

  // Those bits are not built and read back as zero
  chk_fb_hi_zero: assert property (@(posedge clk_i)
    disable iff (srst_i) r_reg.regs[REG_PLLC_FB_HI][7:FBHI_W] == '0)
    else $error("feedback high byte upper bits set");
endmodule

//--- verification/ccp_i2c_master.sv
// Bus master model that drives the configuration port's I2C lines
`timescale 1ns/100ps
module ccp_i2c_master (
  // Clock and bus lines
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  // Both lines start released, so SCL stands high between frames
  initial begin
    scl_o      = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // Steps land just after an edge so the port never sees a race
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Set both lines, then hold them for n clocks
  task automatic drv(input logic c, input logic d, input int n);
    scl_o      = c;
    sda_oe_n_o = d;
    tick(n);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic gen_start();
    drv(scl_o, 1'b1, 8);
    drv(1'b1, 1'b1, 8);
    drv(1'b1, 1'b0, 8);
    drv(1'b0, 1'b0, 2);
  endtask
  // Stop: SDA rises while SCL is high
  task automatic gen_stop();
    drv(1'b0, 1'b0, 8);
    drv(1'b1, 1'b0, 8);
    drv(1'b1, 1'b1, 8);
  endtask
  // SDA moves two clocks after SCL falls, never together with it
  task automatic bit_io(input logic b, output logic r);
    drv(1'b0, b, 8);
    drv(1'b1, b, 8);
    r = sda_i;
    drv(1'b0, b, 2);
  endtask
  // Byte MSB first, then the ninth bit; ack_n high releases SDA
  task automatic xfer(input logic [7:0] tx, input logic ack_n,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_n, ack);
  endtask
endmodule

//--- verification/ccp_port_tb.sv
// Testbench: random block transfers checked against a register model
`timescale 1ns/100ps
module i2c_config_register_port_tb_top;
  import ccp_pkg::*;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        scl, m_oe_n, oe_n, dsda, prog, spr, od1, pref, lock, b1, b2;
  logic [1:0]  asel;
  logic [5:0]  mdiv;
  logic [7:0]  vid, trim;
  logic [10:0] fbd;
  wire         sda = m_oe_n & (oe_n | dsda); // Pulled up unless one pulls
  int          n_errors = 0;
  int          n_checks = 0;
  int          seed = 15;
  int          ptr_m = 0;
  int          mem[6];
  int          mask[6] = '{'hFD, 'hFF, 'hFF, 'hFF, 'hFF, 'h07};

  always #4 clk_i = ~clk_i;

  ccp_port uut (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(dsda), .sda_oe_n_o(oe_n), .nvm_programmed_o(prog),
    .addr_select_o(asel), .pll_a_spread_enable_o(spr),
    .outdiv_one_source_select_o(od1), .pll_c_reference_select_o(pref),
    .nvm_write_lock_o(lock), .variant_identifier_o(vid),
    .crystal_load_trim_o(trim), .pll_c_ref_bypass_one_o(b1),
    .pll_c_ref_bypass_two_o(b2), .pll_c_ref_div_o(mdiv),
    .pll_c_fb_div_o(fbd));
  ccp_i2c_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_n_o(m_oe_n));

  // Compare one value with its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // Control outputs regrouped into register bytes, against the model
  task automatic regs_chk();
    logic [7:0] o[6];
    o = '{{prog, asel, spr, od1, pref, 1'b0, lock}, vid, trim,
          {b1, b2, mdiv}, fbd[7:0], {5'h00, fbd[10:8]}};
    foreach (o[r])
      chk(o[r], 8'(mem[r]));
  endtask
  // Reset held three cycles; model returns to the power-on bytes
  task automatic reset_dut();
    srst_i = 1'b1;
    m.tick(3);
    srst_i = 1'b0;
    m.tick(4);
    mem = '{'h00, 'h00, 'h11, 25, 'hE0, 'h01};
    regs_chk();
  endtask
  // Block write; outputs must not move before the stop
  task automatic wr(input logic [7:0] dev, input int p, input int dq[$],
                    input logic hit);
    logic [7:0] rx;
    logic       a;
    m.gen_start();
    m.xfer(dev, 1'b1, rx, a);
    chk({7'h00, a}, {7'h00, !hit});
    if (hit) begin
      m.xfer(8'(p), 1'b1, rx, a);
      chk({7'h00, a}, 8'h00);
      foreach (dq[i]) begin
        m.xfer(8'(dq[i]), 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
      end
      regs_chk();
      foreach (dq[i])
        if (p + i < 6)
          mem[p + i] = dq[i] & mask[p + i];
      ptr_m = p + dq.size();
    end
    m.gen_stop();
    m.tick(8);
    regs_chk();
  endtask
  // Read n bytes; p below zero reads from the current pointer
  task automatic rd(input logic [7:0] dev, input int p, input int n);
    logic [7:0] rx;
    logic       a;
    m.gen_start();
    if (p >= 0) begin
      m.xfer(dev, 1'b1, rx, a);
      m.xfer(8'(p), 1'b1, rx, a);
      m.gen_start();
      ptr_m = p;
    end
    m.xfer(dev | 8'h01, 1'b1, rx, a);
    chk({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i == n - 1, rx, a);
      chk(rx, ptr_m < 6 ? 8'(mem[ptr_m]) : 8'h00);
      ptr_m++;
    end
    m.gen_stop();
  endtask
  // Print the counts and the verdict, then stop
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hung transfer must not stall the run
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    $display("[ERR] %0t run limit reached", $time);
    end_sim();
  end

  initial begin
    int dq[$];
    int cur;
    cur = 0;
    reset_dut();
    $display("done: defaults");
    // Six bytes from 01h run past 05h; the last one is dropped
    for (int i = 0; i < 6; i++)
      dq.push_back($random(seed) & 'hFF);
    wr(8'hD0, 1, dq, 1'b1);
    rd(8'hD0, 1, 6);
    $display("done: block write and read");
    // Pointer-only write, then a current-pointer read from there
    dq = {};
    wr(8'hD0, 3, dq, 1'b1);
    rd(8'hD0, -1, 2);
    $display("done: current read");
    // Every address code; the old address must go quiet after stop
    for (int k = 1; k < 5; k++) begin
      dq = {($random(seed) & 'h9F) | ((k % 4) << 5)};
      wr(8'hD0 + 8'(2 * cur), 0, dq, 1'b1);
      wr(8'hD0 + 8'(2 * cur), 0, dq, 1'b0);
      cur = k % 4;
      rd(8'hD0 + 8'(2 * cur), 0, 1);
    end
    $display("done: address select");
    reset_dut();
    $display("done: second reset");
    end_sim();
  end
endmodule
